// ### common/rtcct_pkg.sv
// rtcct_pkg: register map, field positions, reset values and
// oscillator-tick counts for the countdown timer and control block.
// assumes a 32.768 kHz oscillator sampled into the 25 MHz ref_clk domain.
package rtcct_pkg;

   // register offsets (8-bit register address space)
   localparam logic [7:0] ADDR_CONTROL_STATUS_ONE = 8'h00;
   localparam logic [7:0] ADDR_CONTROL_STATUS_TWO = 8'h01;
   localparam logic [7:0] ADDR_SQUARE_WAVE_CONTROL = 8'h0d;
   localparam logic [7:0] ADDR_COUNTDOWN_CONTROL = 8'h0e;
   localparam logic [7:0] ADDR_COUNTDOWN_VALUE = 8'h0f;

   // control_status_one fields
   localparam int BIT_EXT_CLOCK_PROBE = 7;
   localparam int BIT_CHAIN_HALT = 5;
   localparam int BIT_POR_OVERRIDE_ON = 3;
   // control_status_two fields
   localparam int BIT_IRQ_LEVEL_OR_PULSE = 4;
   localparam int BIT_MATCH_FLAG = 3;
   localparam int BIT_COUNTDOWN_FLAG = 2;
   localparam int BIT_MATCH_IRQ_ON = 1;
   localparam int BIT_COUNTDOWN_IRQ_ON = 0;
   // square_wave_control fields
   localparam int BIT_SQUARE_OUT_ON = 7;
   localparam int BIT_SQUARE_RATE_LO = 0;
   // countdown_control fields
   localparam int BIT_TIMER_RUN = 7;
   localparam int BIT_TICK_RATE_SEL_LO = 0;

   // reset values of the stored bits
   localparam logic RST_EXT_CLOCK_PROBE = 1'b0;
   localparam logic RST_CHAIN_HALT = 1'b0;
   localparam logic RST_POR_OVERRIDE_ON = 1'b1;
   localparam logic RST_SQUARE_OUT_ON = 1'b1;
   localparam logic [1:0] RST_SQUARE_RATE = 2'h0;
   localparam logic RST_TIMER_RUN = 1'b0;
   localparam logic [1:0] RST_TICK_RATE = 2'h3;

   // tick rate select codes
   localparam logic [1:0] RATE_4096HZ = 2'h0;
   localparam logic [1:0] RATE_64HZ = 2'h1;
   localparam logic [1:0] RATE_1HZ = 2'h2;
   localparam logic [1:0] RATE_1_60HZ = 2'h3;
   // square-wave rate codes
   localparam logic [1:0] SQ_32768HZ = 2'h0;
   localparam logic [1:0] SQ_1024HZ = 2'h1;
   localparam logic [1:0] SQ_32HZ = 2'h2;

   // divider chain: 15 bits of oscillator ticks make one second
   localparam int CHAIN_W = 15;
   localparam logic [14:0] MASK_4096HZ = 15'h0007;
   localparam logic [14:0] MASK_64HZ = 15'h01ff;
   localparam logic [14:0] MASK_1HZ = 15'h7fff;
   localparam logic [5:0] SECONDS_PER_MINUTE_LAST = 6'h3b;
   // square-wave taps into the chain
   localparam int TAP_1024HZ = 4;
   localparam int TAP_32HZ = 9;
   localparam int TAP_1HZ = 14;

   // interrupt pulse widths, in oscillator ticks (32768 per second)
   localparam int OSC_HZ = 32768;
   localparam int PW_N1_4096_DEN = 8192;
   localparam int PW_N1_64_DEN = 128;
   localparam int PW_SLOW_DEN = 64;
   localparam int PW_4096_DEN = 4096;
   localparam logic [9:0] PW_N1_4096 = 10'(OSC_HZ / PW_N1_4096_DEN);
   localparam logic [9:0] PW_N1_64 = 10'(OSC_HZ / PW_N1_64_DEN);
   localparam logic [9:0] PW_SLOW = 10'(OSC_HZ / PW_SLOW_DEN);
   localparam logic [9:0] PW_4096 = 10'(OSC_HZ / PW_4096_DEN);

endpackage : rtcct_pkg

// ### logic/rtcct_osc_sync.sv
// rtcct_osc_sync: brings the oscillator level into ref_clk and marks
// each rising edge with a one-cycle pulse.
// assumes the oscillator is far slower than ref_clk.
`timescale 1ns/100ps
module rtcct_osc_sync (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // oscillator pin
   input wire logic osc_in,
   // synchronised level and rising-edge pulse
   output logic osc_level,
   output logic osc_rise
);

   // all state of the synchroniser
   typedef struct packed {
      logic meta;   // first stage, read only by second
      logic stable; // second stage
      logic last;   // delayed copy for edge detect
   } rtcct_sync_state_t;

   rtcct_sync_state_t state;
   rtcct_sync_state_t next_state;

   // shift the chain
   always_comb begin
      next_state.meta = osc_in;
      next_state.stable = state.meta;
      next_state.last = state.stable;
   end

   // register the chain
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign osc_level = state.stable;
   assign osc_rise = state.stable & ~state.last;

endmodule : rtcct_osc_sync

// ### logic/rtcct_timer.sv
// rtcct_timer: countdown timer, interrupt output and control/status
// registers of the serial clock, with divider chain and square-wave gate.
// assumes the serial-bus logic gives same-clock register strobes and the
// alarm matcher gives a one-cycle match pulse; the oscillator is a pin.
`timescale 1ns/100ps

// Overview of operation
// - timer counts only while run bit set
// - rate field picks 4096, 64, 1, 1/60 Hz
// - countdown value register holds 8-bit n
// - decrement to one, then reload, repeat
// - flag set at each countdown end
// - writing zero clears flag; read shows flag
// - writing one leaves flag unchanged
// - enable bit gates countdown interrupt
// - level mode follows countdown flag
// - pulse mode pulses at each end
// - pulse width depends on rate and n
// - zero load value stops the timer
// - read returns current countdown value
// - halt bit zeroes divider chain, only the 32768 Hz square keeps running
// - match flag clear-on-zero, gated by enable
// - square rate select, disabled means released
module rtcct_timer (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // oscillator pin
   input wire logic osc_in,
   // register access from the serial-bus logic
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // alarm matcher event
   input wire logic match_event,
   // interrupt pin, active low
   output logic irq_n,
   // square-wave pin and its enable, enable low while driving
   output logic square_out,
   output logic square_out_oe_n,
   // to the time counters and test logic
   output logic second_tick,
   output logic ext_clock_probe,
   output logic por_override_on
);

   // all state of the block
   typedef struct packed {
      logic probe;            // ext clock test mode bit
      logic halt;             // divider chain halt bit
      logic por_ovr;          // power-on reset override bit
      logic level_or_pulse;   // 0 level, 1 pulse
      logic match_flag;       // alarm flag
      logic countdown_flag;   // timer flag
      logic match_irq_on;     // alarm interrupt enable
      logic countdown_irq_on; // timer interrupt enable
      logic sq_on;            // square-wave enable
      logic [1:0] sq_rate;    // square-wave rate
      logic timer_run;        // timer enable
      logic [1:0] tick_rate;  // timer source select
      logic [7:0] load;       // loaded countdown value
      logic [7:0] count;      // current countdown value
      logic [14:0] chain;     // oscillator divider chain
      logic [5:0] sixty;      // seconds within a minute
      logic [9:0] pulse_left; // pulse ticks remaining
      logic [7:0] rdata;      // read data register
      logic irq_n;            // interrupt pin
      logic sq;               // square-wave pin
      logic sq_oe_n;          // square-wave enable, low drives
      logic sec;              // one-cycle second tick
   } rtcct_state_t;

   rtcct_state_t state;
   rtcct_state_t next_state;

   // synchronised oscillator
   logic osc_level;
   logic osc_rise;

   rtcct_osc_sync u_osc_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .osc_in(osc_in),
      .osc_level(osc_level),
      .osc_rise(osc_rise)
   );

   // per-cycle decoded events
   logic tick_4096;
   logic tick_64;
   logic tick_1;
   logic tick_1_60;
   logic src_tick;
   logic wr_two;
   logic cd_end;
   logic [9:0] pw;
   logic sq_level;
   logic irq_active;

   // next-state logic
   always_comb begin
      next_state = state;
      wr_two = reg_wr && (reg_addr == rtcct_pkg::ADDR_CONTROL_STATUS_TWO);

      tick_4096 = osc_rise && ((state.chain & rtcct_pkg::MASK_4096HZ) == rtcct_pkg::MASK_4096HZ);
      tick_64 = osc_rise && ((state.chain & rtcct_pkg::MASK_64HZ) == rtcct_pkg::MASK_64HZ);
      tick_1 = osc_rise && (state.chain == rtcct_pkg::MASK_1HZ);
      tick_1_60 = tick_1 && (state.sixty == rtcct_pkg::SECONDS_PER_MINUTE_LAST);

      case (state.tick_rate)
         rtcct_pkg::RATE_4096HZ: src_tick = tick_4096;
         rtcct_pkg::RATE_64HZ: src_tick = tick_64;
         rtcct_pkg::RATE_1HZ: src_tick = tick_1;
         default: src_tick = tick_1_60;
      endcase

      if (state.halt) begin
         next_state.chain = '0;
         next_state.sixty = '0;
      end else if (osc_rise) begin
         // count oscillator ticks
         next_state.chain = state.chain + 15'h0001;
         if (tick_1) begin
            // minute counter for the slowest rate
            next_state.sixty = tick_1_60 ? 6'h00 : state.sixty + 6'h01;
         end
      end
      // second strobe to the time counters
      next_state.sec = tick_1 && !state.halt;

      cd_end = 1'b0;
      if (state.timer_run && (state.load != 8'h00) && src_tick && !state.halt) begin
         if (state.count <= 8'h01) begin
            next_state.count = state.load;
            cd_end = 1'b1;
         end else begin
            next_state.count = state.count - 8'h01;
         end
      end

      // pulse width by rate and n
      if (state.load == 8'h01) begin
         case (state.tick_rate)
            rtcct_pkg::RATE_4096HZ: pw = rtcct_pkg::PW_N1_4096;
            rtcct_pkg::RATE_64HZ: pw = rtcct_pkg::PW_N1_64;
            default: pw = rtcct_pkg::PW_SLOW;
         endcase
      end else begin
         pw = (state.tick_rate == rtcct_pkg::RATE_4096HZ) ? rtcct_pkg::PW_4096 : rtcct_pkg::PW_SLOW;
      end
      // pulse counts down on oscillator ticks
      if (cd_end) begin
         next_state.pulse_left = pw;
      end else if (osc_rise && (state.pulse_left != 10'h000)) begin
         next_state.pulse_left = state.pulse_left - 10'h001;
      end

      // register writes
      if (reg_wr) begin
         case (reg_addr)
            rtcct_pkg::ADDR_CONTROL_STATUS_ONE: begin
               next_state.probe = reg_wdata[rtcct_pkg::BIT_EXT_CLOCK_PROBE];
               next_state.halt = reg_wdata[rtcct_pkg::BIT_CHAIN_HALT];
               next_state.por_ovr = reg_wdata[rtcct_pkg::BIT_POR_OVERRIDE_ON];
            end
            rtcct_pkg::ADDR_CONTROL_STATUS_TWO: begin
               next_state.level_or_pulse = reg_wdata[rtcct_pkg::BIT_IRQ_LEVEL_OR_PULSE];
               next_state.match_irq_on = reg_wdata[rtcct_pkg::BIT_MATCH_IRQ_ON];
               next_state.countdown_irq_on = reg_wdata[rtcct_pkg::BIT_COUNTDOWN_IRQ_ON];
            end
            rtcct_pkg::ADDR_SQUARE_WAVE_CONTROL: begin
               next_state.sq_on = reg_wdata[rtcct_pkg::BIT_SQUARE_OUT_ON];
               next_state.sq_rate = reg_wdata[rtcct_pkg::BIT_SQUARE_RATE_LO +: 2];
            end
            rtcct_pkg::ADDR_COUNTDOWN_CONTROL: begin
               next_state.timer_run = reg_wdata[rtcct_pkg::BIT_TIMER_RUN];
               next_state.tick_rate = reg_wdata[rtcct_pkg::BIT_TICK_RATE_SEL_LO +: 2];
            end
            rtcct_pkg::ADDR_COUNTDOWN_VALUE: begin
               // load n and restart from it
               next_state.load = reg_wdata;
               next_state.count = reg_wdata;
            end
            default: begin
               // other addresses belong to other blocks
            end
         endcase
      end

      if (wr_two && !reg_wdata[rtcct_pkg::BIT_COUNTDOWN_FLAG]) begin
         next_state.countdown_flag = 1'b0;
      end
      // set at countdown end, set wins
      if (cd_end) begin
         next_state.countdown_flag = 1'b1;
      end
      if (wr_two && !reg_wdata[rtcct_pkg::BIT_MATCH_FLAG]) begin
         next_state.match_flag = 1'b0;
      end
      if (match_event) begin
         next_state.match_flag = 1'b1;
      end

      irq_active = (state.countdown_irq_on &&
                    (state.level_or_pulse ? (cd_end || state.pulse_left != 10'h000) :
                     (state.countdown_flag || cd_end))) ||
                   (state.match_irq_on && (state.match_flag || match_event));
      next_state.irq_n = !irq_active;

      case (state.sq_rate)
         rtcct_pkg::SQ_32768HZ: sq_level = osc_level;
         rtcct_pkg::SQ_1024HZ: sq_level = state.chain[rtcct_pkg::TAP_1024HZ];
         rtcct_pkg::SQ_32HZ: sq_level = state.chain[rtcct_pkg::TAP_32HZ];
         default: sq_level = state.chain[rtcct_pkg::TAP_1HZ];
      endcase
      next_state.sq = state.sq_on ? sq_level : 1'b0;
      next_state.sq_oe_n = !state.sq_on;

      // read data, unused bits read zero
      case (reg_addr)
         rtcct_pkg::ADDR_CONTROL_STATUS_ONE: begin
            next_state.rdata = '0;
            next_state.rdata[rtcct_pkg::BIT_EXT_CLOCK_PROBE] = state.probe;
            next_state.rdata[rtcct_pkg::BIT_CHAIN_HALT] = state.halt;
            next_state.rdata[rtcct_pkg::BIT_POR_OVERRIDE_ON] = state.por_ovr;
         end
         rtcct_pkg::ADDR_CONTROL_STATUS_TWO: begin
            next_state.rdata = '0;
            next_state.rdata[rtcct_pkg::BIT_IRQ_LEVEL_OR_PULSE] = state.level_or_pulse;
            next_state.rdata[rtcct_pkg::BIT_MATCH_FLAG] = state.match_flag;
            next_state.rdata[rtcct_pkg::BIT_COUNTDOWN_FLAG] = state.countdown_flag;
            next_state.rdata[rtcct_pkg::BIT_MATCH_IRQ_ON] = state.match_irq_on;
            next_state.rdata[rtcct_pkg::BIT_COUNTDOWN_IRQ_ON] = state.countdown_irq_on;
         end
         rtcct_pkg::ADDR_SQUARE_WAVE_CONTROL: begin
            next_state.rdata = '0;
            next_state.rdata[rtcct_pkg::BIT_SQUARE_OUT_ON] = state.sq_on;
            next_state.rdata[rtcct_pkg::BIT_SQUARE_RATE_LO +: 2] = state.sq_rate;
         end
         rtcct_pkg::ADDR_COUNTDOWN_CONTROL: begin
            next_state.rdata = '0;
            next_state.rdata[rtcct_pkg::BIT_TIMER_RUN] = state.timer_run;
            next_state.rdata[rtcct_pkg::BIT_TICK_RATE_SEL_LO +: 2] = state.tick_rate;
         end
         rtcct_pkg::ADDR_COUNTDOWN_VALUE: next_state.rdata = state.count;
         default: next_state.rdata = '0;
      endcase
   end

   // state register, reset to documented defaults
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state <= '0;
         state.probe <= rtcct_pkg::RST_EXT_CLOCK_PROBE;
         state.halt <= rtcct_pkg::RST_CHAIN_HALT;
         state.por_ovr <= rtcct_pkg::RST_POR_OVERRIDE_ON;
         state.sq_on <= rtcct_pkg::RST_SQUARE_OUT_ON;
         state.sq_rate <= rtcct_pkg::RST_SQUARE_RATE;
         state.timer_run <= rtcct_pkg::RST_TIMER_RUN;
         state.tick_rate <= rtcct_pkg::RST_TICK_RATE;
         state.irq_n <= 1'b1;
         state.sq_oe_n <= 1'b1;
      end else begin
         state <= next_state;
      end
   end

   // outputs straight from the state register
   assign reg_rdata = state.rdata;
   assign irq_n = state.irq_n;
   assign square_out = state.sq;
   assign square_out_oe_n = state.sq_oe_n;
   assign second_tick = state.sec;
   assign ext_clock_probe = state.probe;
   assign por_override_on = state.por_ovr;

endmodule : rtcct_timer

// ### testbench/rtcct_osc_model.sv
// rtcct_osc_model: free-running oscillator source for the timer block.
// assumes the bench scales the oscillator to HALF ref_clk cycles per half period.
`timescale 1ns/100ps
module rtcct_osc_model #(
   parameter int HALF = 8
) (
   // bench clock
   input wire logic ref_clk,
   // oscillator pin level
   output logic osc
);
   // cycles spent in the current half period
   int cnt = 0;
   // current pin level, starts low; crystal runs free, so no gating between uses
   logic lvl = 1'b0;
   // one driver for the pin
   assign osc = lvl;
   // toggle the level every HALF cycles
   always @(posedge ref_clk) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) begin
         lvl <= ~lvl;
      end
   end
endmodule : rtcct_osc_model

// ### testbench/rtcct_timer_asserts.sv
// rtcct_timer_asserts: port-level checks of the countdown timer block.
// assumes register writes are single-cycle strobes on ref_clk.
`timescale 1ns/100ps
module rtcct_timer_asserts (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // watched pins
   input wire logic osc_in,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic match_event,
   input wire logic irq_n,
   input wire logic square_out,
   input wire logic square_out_oe_n,
   input wire logic second_tick,
   input wire logic ext_clock_probe,
   input wire logic por_override_on
);
   // one domain, so one default clock and reset
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_rst_idle;
      $past(rst) |-> irq_n && !second_tick && por_override_on && !ext_clock_probe;
   endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("outputs left reset state");
   property p_flag_hold;
      $fell(reg_rdata[2]) && $past(reg_addr) == 8'h01 && $past(reg_addr, 2) == 8'h01
         |-> $past(reg_wr, 2) && !$past(reg_wdata[2], 2);
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without a zero write");
   property p_tc_read;
      (reg_wr && reg_addr == rtcct_pkg::ADDR_COUNTDOWN_CONTROL) ##1
         (!reg_wr && reg_addr == rtcct_pkg::ADDR_COUNTDOWN_CONTROL) |=> reg_rdata == ($past(reg_wdata, 2) & 8'h83);
   endproperty
   a_tc_read: assert property (p_tc_read) else $error("timer control readback wrong");
   property p_sq_off;
      (reg_wr && reg_addr == rtcct_pkg::ADDR_SQUARE_WAVE_CONTROL && !reg_wdata[7])
         |-> ##[1:3] (square_out_oe_n && !square_out);
   endproperty
   a_sq_off: assert property (p_sq_off) else $error("square pin not released");
   property p_irq_off;
      (reg_wr && reg_addr == 8'h01 && reg_wdata[1:0] == 2'h0) |-> ##[1:3] irq_n;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("interrupt low with enables off");
   property p_probe;
      (reg_wr && reg_addr == 8'h00) ##1 (!reg_wr) [*2]
         |-> por_override_on == $past(reg_wdata[3], 2) && ext_clock_probe == $past(reg_wdata[7], 2);
   endproperty
   a_probe: assert property (p_probe) else $error("test bits not on their pins");
   property p_halt;
      (reg_wr && reg_addr == 8'h00 && reg_wdata[5]) |-> ##2 (!second_tick) [*8];
   endproperty
   a_halt: assert property (p_halt) else $error("second tick while halted");
   property p_irq_min;
      $fell(irq_n) |=> (!irq_n) [*3];
   endproperty
   a_irq_min: assert property (p_irq_min) else $error("interrupt pulse too short");
endmodule : rtcct_timer_asserts
bind rtcct_timer rtcct_timer_asserts u_chk (.ref_clk(ref_clk), .rst(rst), .osc_in(osc_in), .reg_addr(reg_addr),
   .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .match_event(match_event), .irq_n(irq_n),
   .square_out(square_out), .square_out_oe_n(square_out_oe_n), .second_tick(second_tick),
   .ext_clock_probe(ext_clock_probe), .por_override_on(por_override_on));

// ### testbench/rtc_countdown_timer_ctrl_tb.sv
// rtc_countdown_timer_ctrl_tb: register-level tests of the countdown timer block.
// assumes the oscillator model gives one oscillator period per 16 ref_clk cycles.
`timescale 1ns/100ps
module rtc_countdown_timer_ctrl_tb;
   // clock, reset and design pins
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic osc_in;
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic match_event = 1'b0;
   logic irq_n, square_out, square_out_oe_n, second_tick, ext_clock_probe, por_override_on;
   // counters and scratch
   int mismatches = 0;
   int n_tests = 0;
   int c1, c2;
   logic s;
   // ref_clk cycles per oscillator period
   localparam int OSC = 16;
   // 25 mhz clock
   always #20 ref_clk = ~ref_clk;
   // scaled oscillator
   rtcct_osc_model #(.HALF(OSC / 2)) osc (.ref_clk(ref_clk), .osc(osc_in));
   // block under test
   rtcct_timer dut (.ref_clk(ref_clk), .rst(rst), .osc_in(osc_in), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .match_event(match_event), .irq_n(irq_n),
      .square_out(square_out), .square_out_oe_n(square_out_oe_n), .second_tick(second_tick),
      .ext_clock_probe(ext_clock_probe), .por_override_on(por_override_on));
   // verdict and end of run
   task end_sim();
      $display("compares %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim
   // compare seen against expected
   task check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   // cycle count within a few cycles of the target
   task tol(input int c, input int e);
      check(8'(c >= e - 4 && c <= e + 4), 8'h01);
   endtask : tol
   // one register write strobe
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   // read with one cycle latency, then compare
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      repeat (2) @(posedge ref_clk);
      #1 check(reg_rdata, e);
   endtask : rd
   // bounded wait for an interrupt level
   task wait_irq(input logic lvl, input int lim, output int c);
      c = 0;
      while (irq_n !== lvl) begin
         @(posedge ref_clk);
         #1 c++;
         if (c > lim) begin
            mismatches++;
            end_sim();
         end
      end
   endtask : wait_irq
   // one alarm match strobe
   task match();
      @(posedge ref_clk);
      match_event <= 1'b1;
      @(posedge ref_clk);
      match_event <= 1'b0;
   endtask : match
   // main sequence
   initial begin
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      // reset values and an unmapped place
      rd(8'h00, 8'h08);
      rd(8'h01, 8'h00);
      rd(8'h0d, 8'h80);
      rd(8'h0e, 8'h03);
      rd(8'h05, 8'h00);
      check({7'h0, irq_n}, 8'h01);
      for (int r = 0; r < 4; r++) begin
         wr(8'h0e, 8'h7c | 8'(r));
         rd(8'h0e, 8'(r));
      end
      $display("test 1 finished");
      // zero load and run off raise nothing
      wr(8'h01, 8'h01);
      wr(8'h0e, 8'h80);
      wr(8'h0f, 8'h00);
      repeat (400) @(posedge ref_clk);
      rd(8'h01, 8'h01);
      wr(8'h0e, 8'h00);
      wr(8'h0f, 8'hff);
      repeat (400) @(posedge ref_clk);
      rd(8'h0f, 8'hff);
      $display("test 2 finished");
      // pulse mode at 4096 hz, n of 3 then 1
      wr(8'h01, 8'h11);
      wr(8'h0e, 8'h80);
      wr(8'h0f, 8'h03);
      wait_irq(1'b0, 1000, c1);
      wait_irq(1'b1, 1000, c1);
      tol(c1, 8 * OSC);
      wait_irq(1'b0, 1000, c2);
      tol(c1 + c2, 24 * OSC);
      rd(8'h0f, 8'h03);
      repeat (130) @(posedge ref_clk);
      rd(8'h0f, 8'h02);
      rd(8'h01, 8'h15);
      wr(8'h01, 8'h11);
      rd(8'h01, 8'h11);
      match();
      wr(8'h01, 8'h19);
      rd(8'h01, 8'h19);
      wr(8'h01, 8'h15);
      rd(8'h01, 8'h11);
      wr(8'h0f, 8'h01);
      wait_irq(1'b0, 1000, c1);
      wait_irq(1'b1, 1000, c1);
      tol(c1, 4 * OSC);
      wait_irq(1'b0, 1000, c2);
      tol(c1 + c2, 8 * OSC);
      // let the pulse finish before the mode changes
      wait_irq(1'b1, 1000, c1);
      $display("test 3 finished");
      // level mode, enable gating and alarm level
      wr(8'h01, 8'h01);
      wait_irq(1'b0, 300, c1);
      repeat (200) @(posedge ref_clk);
      #1 check({7'h0, irq_n}, 8'h00);
      wr(8'h01, 8'h04);
      repeat (3) @(posedge ref_clk);
      #1 check({7'h0, irq_n}, 8'h01);
      rd(8'h01, 8'h04);
      wr(8'h01, 8'h02);
      match();
      repeat (3) @(posedge ref_clk);
      #1 check({7'h0, irq_n}, 8'h00);
      wr(8'h01, 8'h00);
      repeat (3) @(posedge ref_clk);
      #1 check({7'h0, irq_n}, 8'h01);
      $display("test 4 finished");
      // pulse mode at 64 hz, n of 1
      wr(8'h0e, 8'h81);
      wr(8'h0f, 8'h01);
      wr(8'h01, 8'h11);
      wait_irq(1'b0, 9000, c1);
      wait_irq(1'b1, 9000, c1);
      tol(c1, 256 * OSC);
      wait_irq(1'b0, 9000, c2);
      tol(c1 + c2, 512 * OSC);
      $display("test 5 finished");
      // park rate at 11, halt chain, square wave paths
      wr(8'h0e, 8'h03);
      wr(8'h00, 8'h28);
      rd(8'h00, 8'h28);
      #1 s = square_out;
      repeat (OSC / 2) @(posedge ref_clk);
      #1 check({7'h0, square_out ^ s}, 8'h01);
      wr(8'h0d, 8'h00);
      repeat (3) @(posedge ref_clk);
      #1 check({6'h0, square_out_oe_n, square_out}, 8'h02);
      wr(8'h00, 8'h80);
      repeat (3) @(posedge ref_clk);
      #1 check({6'h0, ext_clock_probe, por_override_on}, 8'h02);
      // 1024 hz tap flips once per 16 oscillator periods
      wr(8'h0d, 8'h81);
      repeat (2) @(posedge ref_clk);
      #1 s = square_out;
      repeat (16 * OSC) @(posedge ref_clk);
      #1 check({6'h0, square_out_oe_n, square_out ^ s}, 8'h01);
      $display("test 6 finished");
      end_sim();
   end
endmodule : rtc_countdown_timer_ctrl_tb
